// *** design/bcrtc_device.sv ***
// device end: eight BCD clock registers with freeze, set, oscillator stop and frequency test
// assumes bus pins arrive asynchronously; power_ok and battery_good come from supply monitors
//
// Overview of operation
// - freeze bit holds visible registers frozen
// - frozen registers show time at freeze
// - internal counters keep running while frozen
// - unfreeze refreshes all visible registers together
// - host keeps freeze clear 500 us
// - host freezes before reading clock data
// - set bit halts updates for loading
// - writing 00h loads set values, resumes
// - 00h after freeze resumes running count
// - setting set or freeze keeps century
// - clearing set bit with freeze bit clear writes century
// - clearing freeze bit keeps century
// - oscillator stop bit halts timekeeping
// - frequency test toggles seconds lsb 512Hz
// - seconds read shows live toggle
// - host writes unused bits as zero
// - select, oe low, we high: read
// - data lines driven only in read
// - reads follow address combinationally
// - select and we low: write
// - packed BCD fields, 24-hour hours
// - month lengths handled; leap years except 04, 24, 44, 64, 84
// - battery flag read-only, 1 when good
`timescale 1ns/1ps
module bcrtc_device
   import bcrtc_pkg::*;
#(
   parameter int TICK_CYC = CLK_HZ
) (
   input  wire logic clk_in,
   input  wire logic reset_in,
   bcrtc_if.device   bus,
   input  wire logic battery_good_in,
   output logic      osc_running_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  cen_reg, yr_reg, mon_reg, dat_reg, wd_reg, hr_reg, mi_reg, se_reg;
   logic [7:0]  v_cen_reg, v_yr_reg, v_mon_reg, v_dat_reg, v_wd_reg, v_hr_reg, v_mi_reg;
   logic [7:0]  v_se_reg;
   logic        set_reg, frz_reg, osc_stop_reg, ftest_reg, ftest_ph_reg;
   logic        set_load_reg;
   logic [31:0] tick_cnt_reg;
   logic [15:0] ft_cnt_reg;
   logic [2:0]  cs_s_reg, oe_s_reg, we_s_reg;
   logic [14:0] addr_s1_reg, addr_s2_reg;
   logic [7:0]  din_s1_reg, din_s2_reg;
   logic [1:0]  batt_s_reg;
   logic        tick;
   logic        wr_act, wr_start, freeze;
   logic [7:0]  din;
   logic [14:0] waddr;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      // bcd year divisible by four, but years 04, 24, 44, 64, 84 count as common
      leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && y[3:2] != 2'b01 && y[3:2] != 2'b11)
                            : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
      unique case (m)
         8'h02:                         month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11:    month_days = 8'h30;
         default:                       month_days = 8'h31;
      endcase
   endfunction : month_days

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers on the bus pins; third stage for edges
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cs_s_reg    <= 3'h7;
         oe_s_reg    <= 3'h7;
         we_s_reg    <= 3'h7;
         addr_s1_reg <= 15'h0000;
         addr_s2_reg <= 15'h0000;
         din_s1_reg  <= 8'h00;
         din_s2_reg  <= 8'h00;
         batt_s_reg  <= 2'h3;
      end else begin
         cs_s_reg    <= {cs_s_reg[1:0], bus.chip_sel_n | ~bus.power_ok};
         oe_s_reg    <= {oe_s_reg[1:0], bus.out_en_n};
         we_s_reg    <= {we_s_reg[1:0], bus.wr_strobe_n};
         addr_s1_reg <= bus.addr;
         addr_s2_reg <= addr_s1_reg;
         din_s1_reg  <= bus.host_dq_o;
         din_s2_reg  <= din_s1_reg;
         batt_s_reg  <= {batt_s_reg[0], battery_good_in};
      end
   end

   assign wr_act   = ~cs_s_reg[1] & ~we_s_reg[1];
   assign wr_start = wr_act & (cs_s_reg[2] | we_s_reg[2]);
   assign din      = din_s2_reg;
   assign waddr    = addr_s2_reg;
   assign freeze   = set_reg | frz_reg;

   ////////////////////////////////////////////////////////////////////////
   // oscillator stop halts tick
   assign tick = ~osc_stop_reg && (tick_cnt_reg == 32'(TICK_CYC - 1));
   assign osc_running_out = ~osc_stop_reg;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         tick_cnt_reg <= 32'h0000_0000;
      end else if (osc_stop_reg || tick) begin
         tick_cnt_reg <= 32'h0000_0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ft_cnt_reg   <= 16'h0000;
         ftest_ph_reg <= 1'b0;
      end else if (osc_stop_reg || !ftest_reg) begin
         ft_cnt_reg   <= 16'h0000;
         ftest_ph_reg <= 1'b0;
      end else if (ft_cnt_reg == 16'(FTEST_HALF_CYC - 1)) begin
         ft_cnt_reg   <= 16'h0000;
         ftest_ph_reg <= ~ftest_ph_reg;
      end else begin
         ft_cnt_reg   <= ft_cnt_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control bits and the set-load event
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         set_reg      <= 1'b0;
         frz_reg      <= 1'b0;
         osc_stop_reg <= 1'b0;
         ftest_reg    <= 1'b0;
         set_load_reg <= 1'b0;
      end else begin
         set_load_reg <= 1'b0;
         if (wr_start && waddr == ADDR_CONTROL) begin
            frz_reg      <= din[CTL_FREEZE_BIT];
            set_reg      <= din[CTL_SET_BIT];
            set_load_reg <= set_reg & ~din[CTL_SET_BIT];
         end
         if (wr_start && waddr == ADDR_SECONDS) begin
            osc_stop_reg <= din[SEC_OSC_STOP_BIT];
         end
         if (wr_start && waddr == ADDR_WEEKDAY) begin
            ftest_reg    <= din[DAY_FTEST_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // internal counters run during freeze bit, halt while set bit is on
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cen_reg <= RST_CENTURY;
         yr_reg  <= RST_YEAR;
         mon_reg <= RST_MONTH;
         dat_reg <= RST_DATE;
         wd_reg  <= RST_WEEKDAY;
         hr_reg  <= 8'h00;
         mi_reg  <= 8'h00;
         se_reg  <= 8'h00;
      end else if (set_load_reg) begin
         cen_reg <= v_cen_reg;
         yr_reg  <= v_yr_reg;
         mon_reg <= v_mon_reg;
         dat_reg <= v_dat_reg;
         wd_reg  <= v_wd_reg;
         hr_reg  <= v_hr_reg;
         mi_reg  <= v_mi_reg;
         se_reg  <= v_se_reg;
      end else if (tick && !set_reg) begin
         se_reg <= (se_reg == 8'h59) ? 8'h00 : bcd_inc(se_reg);
         if (se_reg == 8'h59) begin
            mi_reg <= (mi_reg == 8'h59) ? 8'h00 : bcd_inc(mi_reg);
            if (mi_reg == 8'h59) begin
               hr_reg <= (hr_reg == 8'h23) ? 8'h00 : bcd_inc(hr_reg);
               if (hr_reg == 8'h23) begin
                  wd_reg <= (wd_reg == 8'h07) ? 8'h01 : bcd_inc(wd_reg);
                  if (dat_reg == month_days(mon_reg, yr_reg)) begin
                     dat_reg <= 8'h01;
                     mon_reg <= (mon_reg == 8'h12) ? 8'h01 : bcd_inc(mon_reg);
                     if (mon_reg == 8'h12) begin
                        yr_reg <= (yr_reg == 8'h99) ? 8'h00 : bcd_inc(yr_reg);
                        if (yr_reg == 8'h99) begin
                           cen_reg <= (cen_reg == 8'h39) ? 8'h00 : bcd_inc(cen_reg);
                        end
                     end
                  end else begin
                     dat_reg <= bcd_inc(dat_reg);
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // visible copies: follow counters unless frozen, take host writes
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         v_cen_reg <= RST_CENTURY;
         v_yr_reg  <= RST_YEAR;
         v_mon_reg <= RST_MONTH;
         v_dat_reg <= RST_DATE;
         v_wd_reg  <= RST_WEEKDAY;
         v_hr_reg  <= 8'h00;
         v_mi_reg  <= 8'h00;
         v_se_reg  <= 8'h00;
      end else if (wr_start) begin
         unique case (waddr)
            ADDR_CONTROL: if (set_reg && !din[CTL_SET_BIT] && !din[CTL_FREEZE_BIT]) begin
               v_cen_reg <= din & MASK_CENTURY;
            end
            ADDR_SECONDS: v_se_reg  <= din & MASK_SECONDS;
            ADDR_MINUTES: v_mi_reg  <= din & MASK_MINUTES;
            ADDR_HOURS:   v_hr_reg  <= din & MASK_HOURS;
            ADDR_WEEKDAY: v_wd_reg  <= din & MASK_WEEKDAY;
            ADDR_DATE:    v_dat_reg <= din & MASK_DATE;
            ADDR_MONTH:   v_mon_reg <= din & MASK_MONTH;
            ADDR_YEAR:    v_yr_reg  <= din;
            default:      ;
         endcase
      end else if (!freeze && !set_load_reg) begin
         v_cen_reg <= cen_reg;
         v_yr_reg  <= yr_reg;
         v_mon_reg <= mon_reg;
         v_dat_reg <= dat_reg;
         v_wd_reg  <= wd_reg;
         v_hr_reg  <= hr_reg;
         v_mi_reg  <= mi_reg;
         v_se_reg  <= se_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data follows address without strobe
   always_comb begin
      unique case (bus.addr)
         ADDR_CONTROL: bus.dev_dq_o = {set_reg, frz_reg, v_cen_reg[5:0]};
         ADDR_SECONDS: bus.dev_dq_o = {osc_stop_reg, v_se_reg[6:1],
                                       ftest_reg ? ftest_ph_reg : v_se_reg[0]};
         ADDR_MINUTES: bus.dev_dq_o = v_mi_reg;
         ADDR_HOURS:   bus.dev_dq_o = v_hr_reg;
         ADDR_WEEKDAY: bus.dev_dq_o = {batt_s_reg[1], ftest_reg, v_wd_reg[5:0]};
         ADDR_DATE:    bus.dev_dq_o = v_dat_reg;
         ADDR_MONTH:   bus.dev_dq_o = v_mon_reg;
         ADDR_YEAR:    bus.dev_dq_o = v_yr_reg;
         default:      bus.dev_dq_o = 8'h00;
      endcase
   end

   // drive only in read mode with power good
   assign bus.dev_dq_oe = bus.power_ok & ~bus.chip_sel_n & ~bus.out_en_n & bus.wr_strobe_n;
endmodule : bcrtc_device

// *** design/bcrtc_host.sv ***
// host end: runs single register reads and writes on the parallel bus from a simple command port
// assumes the device answers reads combinationally; same 20 MHz clock as the device model
`timescale 1ns/1ps
module bcrtc_host
   import bcrtc_pkg::*;
#(
   parameter int STROBE_CYC = 8
) (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   bcrtc_if.host            bus,
   input  wire logic [14:0] cmd_addr_in,
   input  wire logic [7:0]  cmd_wdata_in,
   input  wire logic        cmd_write_in,
   input  wire logic        cmd_read_in,
   output logic             cmd_busy_out,
   output logic [7:0]       cmd_rdata_out,
   output logic             cmd_done_out
);
   typedef enum logic [1:0] {
      BCH_IDLE  = 2'b00,
      BCH_WRITE = 2'b01,
      BCH_READ  = 2'b10,
      BCH_GAP   = 2'b11
   } bch_state_e;

   bch_state_e  state_reg;
   logic [7:0]  cnt_reg;
   logic [7:0]  rd_s1_reg;

   assign cmd_busy_out = (state_reg != BCH_IDLE);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_s1_reg <= 8'h00;
      end else begin
         // resolved lines, so an undriven bus reads as pulled high
         rd_s1_reg <= bus.dq;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg        <= BCH_IDLE;
         cnt_reg          <= 8'h00;
         bus.addr         <= 15'h0000;
         bus.chip_sel_n   <= 1'b1;
         bus.out_en_n     <= 1'b1;
         bus.wr_strobe_n  <= 1'b1;
         bus.host_dq_o    <= 8'h00;
         bus.host_dq_oe   <= 1'b0;
         cmd_rdata_out    <= 8'h00;
         cmd_done_out     <= 1'b0;
      end else begin
         cmd_done_out <= 1'b0;
         unique case (state_reg)
            BCH_IDLE: begin
               cnt_reg <= 8'h00;
               if (cmd_write_in) begin
                  // caller supplies zeros in unused bits
                  bus.addr        <= cmd_addr_in;
                  bus.host_dq_o   <= cmd_wdata_in;
                  bus.host_dq_oe  <= 1'b1;
                  bus.chip_sel_n  <= 1'b0;
                  bus.wr_strobe_n <= 1'b0;
                  state_reg       <= BCH_WRITE;
               end else if (cmd_read_in) begin
                  bus.addr        <= cmd_addr_in;
                  bus.chip_sel_n  <= 1'b0;
                  bus.out_en_n    <= 1'b0;
                  state_reg       <= BCH_READ;
               end
            end
            BCH_WRITE, BCH_READ: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == 8'(STROBE_CYC - 1)) begin
                  if (state_reg == BCH_READ) begin
                     cmd_rdata_out <= rd_s1_reg;
                  end
                  bus.chip_sel_n  <= 1'b1;
                  bus.out_en_n    <= 1'b1;
                  bus.wr_strobe_n <= 1'b1;
                  cnt_reg         <= 8'h00;
                  state_reg       <= BCH_GAP;
               end
            end
            BCH_GAP: begin
               // hold data past strobe end, then recover
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == 8'(STROBE_CYC - 1)) begin
                  bus.host_dq_oe <= 1'b0;
                  cmd_done_out   <= 1'b1;
                  state_reg      <= BCH_IDLE;
               end
            end
         endcase
      end
   end
endmodule : bcrtc_host

// *** design/bcrtc_if.sv ***
// interface: parallel byte bus between host and clock/calendar device
// data line resolves from the two output enables; active-low strobes
`timescale 1ns/1ps
interface bcrtc_if;
   logic [14:0] addr;
   logic        chip_sel_n;
   logic        out_en_n;
   logic        wr_strobe_n;
   logic [7:0]  host_dq_o;
   logic        host_dq_oe;
   logic [7:0]  dev_dq_o;
   logic        dev_dq_oe;
   logic        power_ok;
   wire  [7:0]  dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 8'hFF);

   modport device (
      input  addr, chip_sel_n, out_en_n, wr_strobe_n, host_dq_o, power_ok,
      output dev_dq_o, dev_dq_oe
   );
   modport host (
      input  dq,
      output addr, chip_sel_n, out_en_n, wr_strobe_n, host_dq_o, host_dq_oe
   );
endinterface : bcrtc_if

// *** design/bcrtc_pkg.sv ***
// package: register map, field positions and timing counts of the clock/calendar block
// assumes a single 20 MHz clock shared by both ends
package bcrtc_pkg;
   localparam int          CLK_HZ            = 20_000_000;
   localparam int          ADDR_W            = 15;
   // clock registers sit in the eight uppermost locations
   localparam logic [14:0] ADDR_CONTROL      = 15'h7FF8;
   localparam logic [14:0] ADDR_SECONDS      = 15'h7FF9;
   localparam logic [14:0] ADDR_MINUTES      = 15'h7FFA;
   localparam logic [14:0] ADDR_HOURS        = 15'h7FFB;
   localparam logic [14:0] ADDR_WEEKDAY      = 15'h7FFC;
   localparam logic [14:0] ADDR_DATE         = 15'h7FFD;
   localparam logic [14:0] ADDR_MONTH        = 15'h7FFE;
   localparam logic [14:0] ADDR_YEAR         = 15'h7FFF;
   localparam int          CTL_SET_BIT       = 7;
   localparam int          CTL_FREEZE_BIT    = 6;
   localparam int          SEC_OSC_STOP_BIT  = 7;
   localparam int          DAY_BATT_BIT      = 7;
   localparam int          DAY_FTEST_BIT     = 6;
   localparam logic [7:0]  MASK_CENTURY      = 8'h3F;
   localparam logic [7:0]  MASK_SECONDS      = 8'h7F;
   localparam logic [7:0]  MASK_MINUTES      = 8'h7F;
   localparam logic [7:0]  MASK_HOURS        = 8'h3F;
   localparam logic [7:0]  MASK_WEEKDAY      = 8'h07;
   localparam logic [7:0]  MASK_DATE         = 8'h3F;
   localparam logic [7:0]  MASK_MONTH        = 8'h1F;
   localparam int          FTEST_HZ          = 512;
   localparam int          FTEST_HALF_CYC    = CLK_HZ / (2 * FTEST_HZ);
   // least time the freeze bit stays clear before a refresh is certain
   localparam int          FREEZE_CLEAR_US   = 500;
   localparam int          FREEZE_CLEAR_CYC  = (FREEZE_CLEAR_US * (CLK_HZ / 1_000_000));
   localparam logic [7:0]  CTL_RELEASE       = 8'h00;
   // reset values of the time counters
   localparam logic [7:0]  RST_CENTURY       = 8'h20;
   localparam logic [7:0]  RST_YEAR          = 8'h00;
   localparam logic [7:0]  RST_MONTH         = 8'h01;
   localparam logic [7:0]  RST_DATE          = 8'h01;
   localparam logic [7:0]  RST_WEEKDAY       = 8'h01;
endpackage : bcrtc_pkg

// *** tb/bcrtc_assertions.sv ***
// checker: properties of the byte bus joining the host end and the device end
// assumes one clock domain; the bench instantiates it beside the interface
`timescale 1ns/1ps
module bcrtc_assertions
   import bcrtc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic [14:0] addr,
   input  wire logic        chip_sel_n,
   input  wire logic        out_en_n,
   input  wire logic        wr_strobe_n,
   input  wire logic [7:0]  host_dq_o,
   input  wire logic        host_dq_oe,
   input  wire logic [7:0]  dev_dq_o,
   input  wire logic        dev_dq_oe,
   input  wire logic        power_ok
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic rd;
   assign rd = !chip_sel_n && !out_en_n && wr_strobe_n && power_ok;
   sequence s_strobe_held; !wr_strobe_n [*3]; endsequence
   sequence s_idle_gap; chip_sel_n [*3]; endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_deselect_hiz: assert property (chip_sel_n |-> !dev_dq_oe)
      else $error("data driven while deselected");
   chk_oe_off_hiz: assert property (out_en_n |-> !dev_dq_oe)
      else $error("data driven with output enable off");
   chk_powerfail_hiz: assert property (!power_ok |-> !dev_dq_oe)
      else $error("data driven during power fail");
   chk_read_drives: assert property (rd |-> dev_dq_oe)
      else $error("read mode without data drive");
   chk_write_no_drive: assert property (!chip_sel_n && !wr_strobe_n |-> !dev_dq_oe)
      else $error("device drives during write");
   chk_no_contention: assert property (!(host_dq_oe && dev_dq_oe))
      else $error("both ends drive data");
   chk_bcd_digits: assert property (
      rd && addr >= ADDR_CONTROL && addr != ADDR_WEEKDAY |-> dev_dq_o[3:0] <= 4'h9)
      else $error("low digit not decimal");
   chk_hours_range: assert property (rd && addr == ADDR_HOURS |-> dev_dq_o <= 8'h23)
      else $error("hours beyond 23");
   chk_month_range: assert property (
      rd && addr == ADDR_MONTH |-> dev_dq_o inside {[8'h01:8'h12]})
      else $error("month out of range");
   chk_date_range: assert property (
      rd && addr == ADDR_DATE |-> dev_dq_o inside {[8'h01:8'h31]})
      else $error("date out of range");
   chk_strobe_min_low: assert property ($fell(wr_strobe_n) |-> s_strobe_held)
      else $error("write strobe too short");
   chk_access_gap: assert property ($rose(chip_sel_n) |-> s_idle_gap)
      else $error("select gap too short");
   chk_wdata_steady: assert property (
      !wr_strobe_n && !$fell(wr_strobe_n) |-> host_dq_oe && $stable(host_dq_o) && $stable(addr))
      else $error("write data or address moved");
endmodule : bcrtc_assertions

// *** tb/bcrtc_bench.sv ***
// bench: host end and device end joined by the interface, driven from the command port
// assumes a shortened one-second tick; power and battery monitors come from here
`timescale 1ns/1ps
module bcrtc_bench;
   import bcrtc_pkg::*;
   localparam int TICK = 2000;
   logic        clk_in;
   logic        reset_in;
   logic        batt;
   logic        cmd_wr;
   logic        cmd_rd;
   logic [14:0] cmd_addr;
   logic [7:0]  cmd_wdata;
   logic        busy;
   logic        done;
   logic [7:0]  rdata;
   logic        osc_run;
   int          num_errors;
   int          tests_run;
   int          cyc = 0;
   bcrtc_if bus();
   bcrtc_device #(.TICK_CYC(TICK)) u_bcrtc_device (.clk_in(clk_in), .reset_in(reset_in),
      .bus(bus), .battery_good_in(batt), .osc_running_out(osc_run));
   bcrtc_host #(.STROBE_CYC(8)) u_bcrtc_host (.clk_in(clk_in), .reset_in(reset_in),
      .bus(bus), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_write_in(cmd_wr),
      .cmd_read_in(cmd_rd), .cmd_busy_out(busy), .cmd_rdata_out(rdata), .cmd_done_out(done));
   bcrtc_assertions u_bcrtc_assertions (.clk_in(clk_in), .reset_in(reset_in),
      .addr(bus.addr), .chip_sel_n(bus.chip_sel_n), .out_en_n(bus.out_en_n),
      .wr_strobe_n(bus.wr_strobe_n), .host_dq_o(bus.host_dq_o), .host_dq_oe(bus.host_dq_oe),
      .dev_dq_o(bus.dev_dq_o), .dev_dq_oe(bus.dev_dq_oe), .power_ok(bus.power_ok));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) cyc++;
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic bus_op(input logic w, input logic [14:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      int n;
      @(posedge clk_in);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= w;
      cmd_rd <= !w;
      @(posedge clk_in);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      #1;
      check("busy_on", {7'h00, busy}, 8'h01);
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (done !== 1'b1 && n < 100);
      if (n >= 100) check("done_seen", 8'h00, 8'h01);
      check("busy_off", {7'h00, busy}, 8'h00);
      q = rdata;
   endtask : bus_op
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus_op(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [14:0] a, output logic [7:0] q);
      bus_op(1'b0, a, 8'h00, q);
   endtask : rd
   function automatic int bcd2i(input logic [7:0] b);
      return b[7:4] * 10 + b[3:0];
   endfunction : bcd2i
   ////////////////////////////////////////////////////////////////////////////
   // load two seconds before the end of a century, then watch every field roll over
   task automatic t_set_rollover();
      // set values keep unused bits zero
      logic [7:0] setv [7] = '{8'h58, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
      logic [7:0] expv [8] = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h81, 8'h01, 8'h01, 8'h00};
      logic [7:0] q;
      wr(ADDR_CONTROL, 8'h80);
      for (int i = 0; i < 7; i++) wr(ADDR_SECONDS + 15'(i), setv[i]);
      wr(ADDR_CONTROL, 8'h19);
      repeat (2 * TICK + 50) @(posedge clk_in);
      wr(ADDR_CONTROL, 8'h40);
      for (int i = 0; i < 8; i++) begin
         rd(ADDR_CONTROL + 15'(i), q);
         if (i == 1) check("sec_roll", {7'h00, q <= 8'h01}, 8'h01);
         else check("roll_field", q, expv[i]);
      end
   endtask : t_set_rollover
   task automatic t_freeze_hold();
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] q;
      int         c1;
      int         n;
      int         d;
      rd(ADDR_SECONDS, s1);
      c1 = cyc;
      repeat (3 * TICK) @(posedge clk_in);
      rd(ADDR_SECONDS, s2);
      check("frozen_sec", s2, s1);
      wr(ADDR_CONTROL, CTL_RELEASE);
      repeat (FREEZE_CLEAR_CYC) @(posedge clk_in);
      // freeze with century bits that must be ignored
      wr(ADDR_CONTROL, 8'h45);
      rd(ADDR_SECONDS, s2);
      n = (cyc - c1) / TICK;
      d = bcd2i(s2) - bcd2i(s1);
      check("run_on", {7'h00, d >= n - 1 && d <= n + 1}, 8'h01);
      rd(ADDR_CONTROL, q);
      check("century_kept", q, 8'h60);
      wr(ADDR_CONTROL, CTL_RELEASE);
      rd(ADDR_CONTROL, q);
      check("century_unfrozen", q, 8'h20);
   endtask : t_freeze_hold
   task automatic t_osc_stop();
      logic [7:0] a;
      logic [7:0] b;
      wr(ADDR_SECONDS, 8'h80);
      check("osc_off", {7'h00, osc_run}, 8'h00);
      rd(ADDR_SECONDS, a);
      repeat (2 * TICK) @(posedge clk_in);
      rd(ADDR_SECONDS, b);
      check("osc_stopped", b, a);
      check("osc_bit", {7'h00, a[7]}, 8'h01);
      wr(ADDR_SECONDS, 8'h00);
      check("osc_on", {7'h00, osc_run}, 8'h01);
   endtask : t_osc_stop
   task automatic t_freq_test();
      logic [7:0] a;
      logic [7:0] b;
      wr(ADDR_WEEKDAY, 8'h41);
      wr(ADDR_CONTROL, 8'h40);
      rd(ADDR_SECONDS, a);
      // two reads half a test period apart
      repeat (FTEST_HALF_CYC - 20) @(posedge clk_in);
      rd(ADDR_SECONDS, b);
      check("ftest_lsb", {7'h00, a[0] ^ b[0]}, 8'h01);
      check("ftest_upper", {1'b0, b[7:1]}, {1'b0, a[7:1]});
      wr(ADDR_WEEKDAY, 8'h01);
      wr(ADDR_CONTROL, CTL_RELEASE);
   endtask : t_freq_test
   task automatic t_batt_power();
      logic [7:0] q;
      @(posedge clk_in);
      batt <= 1'b0;
      rd(ADDR_WEEKDAY, q);
      check("batt_low", {7'h00, q[7]}, 8'h00);
      batt <= 1'b1;
      bus.power_ok <= 1'b0;
      rd(ADDR_SECONDS, q);
      check("pf_hiz", q, 8'hFF);
      bus.power_ok <= 1'b1;
   endtask : t_batt_power
   task automatic give_verdict();
      if (num_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge clk_in);
      num_errors++;
      give_verdict();
   end
   initial begin
      reset_in = 1'b1;
      batt = 1'b1;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_addr = 15'h0000;
      cmd_wdata = 8'h00;
      bus.power_ok = 1'b1;
      num_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      t_set_rollover();
      t_freeze_hold();
      t_osc_stop();
      t_freq_test();
      t_batt_power();
      give_verdict();
   end
endmodule : bcrtc_bench
